// >>> design/vpw_bus_error_handler.sv
/*
  Error detection and recovery of a J1850 VPW byte link controller, AHB-Lite slave.
  Assumes symbols arrive decoded, one-cycle valid, on clk; bus_rx is the raw pin.
*/
`timescale 1ns/10ps
`default_nettype none
module vpw_bus_error_handler
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire vpw_err_pkg::sym_t sym,
  input wire vpw_err_pkg::tx_stat_t tx,
  input wire logic bus_rx,
  output logic tx_enable,
  output logic tx_abort,
  output logic irq
);
  import vpw_err_pkg::*;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc_step = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction : crc_step

  function automatic logic [7:0] svr_code(input flags_t f);
    if (f.inv)
      svr_code = SVR_INVALID;
    else if (f.crc)
      svr_code = SVR_CRC;
    else if (f.txerr)
      svr_code = SVR_TXERR;
    else if (f.eof)
      svr_code = SVR_EOF;
    else if (f.loss_of_arbitration_flag)
      svr_code = SVR_LOA;
    else
      svr_code = SVR_NONE;
  endfunction : svr_code

  // pin synchroniser; only the second stage is looked at
  logic bus_m_r;
  logic bus_s_r;
  logic [DRIVE_DELAY-1:0] drv_d_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_m_r <= 1'b0;
      bus_s_r <= 1'b0;
      drv_d_r <= '0;
    end
    else
    begin
      bus_m_r <= bus_rx;
      bus_s_r <= bus_m_r;
      // drive delayed to line up with the synchronised echo
      drv_d_r <= {drv_d_r[DRIVE_DELAY-2:0], tx.drive_active};
    end
  end

  logic drv_echo;
  assign drv_echo = drv_d_r[DRIVE_DELAY-1];

  logic ie_r, ie_nxt;
  logic ignore_message_control_r, ignore_message_control_nxt;
  logic tx_pending_r, tx_pending_nxt;
  logic need_eof_r, need_eof_nxt;
  logic tx_enable_r, tx_enable_nxt;
  logic tx_abort_r, tx_abort_nxt;
  flags_t flags_r, flags_nxt;
  rx_state_t state_r, state_nxt;
  logic [7:0] crc_r, crc_nxt;
  logic [2:0] bitcnt_r, bitcnt_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [31:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  logic addr_phase;
  logic sym_live;
  logic crc_bad;
  flags_t set_v;
  flags_t clr_v;
  logic [7:0] svr;

  assign addr_phase = hsel && hready && htrans[1];
  assign sym_live = sym.valid && (!ignore_message_control_r || sym.kind == SYM_SOF || sym.kind == SYM_BRK);
  assign svr = svr_code(flags_r);
  assign crc_bad = sym_live && state_r == ST_FRAME && sym.kind == SYM_EOD
                   && bitcnt_r == 3'h0 && crc_r != CRC_RESIDUE;

  always_comb
  begin
    set_v = '0;
    clr_v = '0;
    state_nxt = state_r;
    crc_nxt = crc_r;
    bitcnt_nxt = bitcnt_r;
    tx_abort_nxt = 1'b0;
    need_eof_nxt = need_eof_r;
    ie_nxt = ie_r;
    ignore_message_control_nxt = ignore_message_control_r;
    tx_pending_nxt = tx_pending_r;
    wr_pend_nxt = addr_phase && hwrite;
    wr_addr_nxt = addr_phase ? haddr : wr_addr_r;
    hrdata_nxt = hrdata_r;

    // receive framing and CRC check
    if (sym_live)
    begin
      if (sym.kind == SYM_EOF)
      begin
        set_v.eof = 1'b1;
        need_eof_nxt = 1'b0;
      end
      if (sym.kind == SYM_BRK)
      begin
        set_v.inv = 1'b1;
        state_nxt = ST_WAIT_IDLE;
        tx_abort_nxt = tx.sending;
      end
      else
      begin
        case (state_r)
          ST_HUNT:
          begin
            if (sym.kind == SYM_SOF)
            begin
              state_nxt = ST_FRAME;
              crc_nxt = CRC_PRESET;
              bitcnt_nxt = 3'h0;
            end
          end
          ST_FRAME:
          begin
            case (sym.kind)
              SYM_DATA0, SYM_DATA1:
              begin
                crc_nxt = crc_step(crc_r, sym.kind == SYM_DATA1);
                bitcnt_nxt = bitcnt_r + 3'h1;
              end
              SYM_EOD:
              begin
                if (bitcnt_r != 3'h0)
                begin
                  set_v.inv = 1'b1;
                  state_nxt = ST_WAIT_EOF;
                end
                else if (crc_bad)
                begin
                  set_v.crc = 1'b1;
                  state_nxt = ST_WAIT_EOF;
                end
                else
                  crc_nxt = CRC_PRESET; // in-frame response may follow
              end
              SYM_EOF:
              begin
                if (bitcnt_r != 3'h0)
                  set_v.inv = 1'b1;
                state_nxt = ST_HUNT;
              end
              default:
              begin
                set_v.inv = 1'b1;
                state_nxt = ST_WAIT_EOF;
              end
            endcase
          end
          ST_WAIT_EOF, ST_WAIT_IDLE:
          begin
            // EOF marks the idle bus; hunt then waits for SOF
            if (sym.kind == SYM_EOF)
              state_nxt = ST_HUNT;
          end
          default:
            state_nxt = ST_HUNT;
        endcase
      end

      // errors in our own message
      if (tx.sending)
      begin
        if (sym.kind == SYM_INVALID)
        begin
          set_v.inv = 1'b1;
          set_v.txerr = 1'b1;
          tx_abort_nxt = 1'b1;
        end
        if ((sym.kind == SYM_EOD || sym.kind == SYM_EOF) && bitcnt_r != 3'h0)
        begin
          set_v.txerr = 1'b1;
          tx_abort_nxt = 1'b1;
        end
        if (tx.eod_phase && (sym.kind == SYM_DATA0 || sym.kind == SYM_DATA1
            || sym.kind == SYM_SOF))
        begin
          set_v.inv = 1'b1;
          tx_abort_nxt = 1'b1;
        end
      end
    end

    // bus level disagrees with our own drive
    if (tx.sending && !ignore_message_control_r)
    begin
      if (drv_echo && !bus_s_r)
      begin
        set_v.txerr = 1'b1;
        set_v.inv = 1'b1;
        tx_abort_nxt = 1'b1;
      end
      else if (!drv_echo && bus_s_r && !tx.drive_active)
      begin
        set_v.loss_of_arbitration_flag = 1'b1;
        tx_abort_nxt = 1'b1;
      end
    end
    if (tx_abort_nxt)
      need_eof_nxt = 1'b1;
    // state vector read clears only the reported source
    if (addr_phase && !hwrite)
    begin
      hrdata_nxt = 32'h0000_0000;
      if (haddr == ADDR_CTRL)
      begin
        hrdata_nxt[CTRL_IE_BIT] = ie_r;
        hrdata_nxt[CTRL_IGNORE_MESSAGE_CONTROL_BIT] = ignore_message_control_r;
      end
      else if (haddr == ADDR_SVR)
      begin
        hrdata_nxt[7:0] = svr;
        if (flags_r.inv)
          clr_v.inv = 1'b1;
        else if (flags_r.crc)
          clr_v.crc = 1'b1;
        else if (flags_r.txerr)
          clr_v.txerr = 1'b1;
        else if (flags_r.eof)
          clr_v.eof = 1'b1;
        else
          clr_v.loss_of_arbitration_flag = 1'b1;
      end
      else if (haddr == ADDR_STATUS)
        hrdata_nxt[12:0] = {need_eof_r, tx_pending_r, bus_s_r, state_r, bitcnt_r,
                            flags_r};
    end

    // a new hardware event wins over the clearing read
    flags_nxt = (flags_r & ~clr_v) | set_v;
    // SOF or break releases ignore mode and is itself received
    if (sym.valid && (sym.kind == SYM_SOF || sym.kind == SYM_BRK))
      ignore_message_control_nxt = 1'b0;

    if (wr_pend_r && wr_addr_r == ADDR_CTRL)
    begin
      ie_nxt = hwdata[CTRL_IE_BIT];
      if (hwdata[CTRL_IGNORE_MESSAGE_CONTROL_BIT])
        ignore_message_control_nxt = 1'b1;
      if (hwdata[CTRL_TXGO_BIT])
        tx_pending_nxt = 1'b1;
    end

    // an abort drops the request; only a new command retries
    if (tx_abort_nxt)
      tx_pending_nxt = 1'b0;
    else if (tx.sending)
      tx_pending_nxt = 1'b0;

    if (ignore_message_control_r && !sym_live)
    begin
      flags_nxt = '0;
      state_nxt = ST_HUNT;
    end

    // no start while bus is held active or an EOF is owed
    tx_enable_nxt = tx_pending_nxt && !need_eof_nxt && !bus_s_r
                    && state_nxt == ST_HUNT && !tx_abort_nxt;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ie_r <= CTRL_IE_RESET;
      ignore_message_control_r <= CTRL_IGNORE_MESSAGE_CONTROL_RESET;
      tx_pending_r <= 1'b0;
      need_eof_r <= 1'b0;
      tx_enable_r <= 1'b0;
      tx_abort_r <= 1'b0;
      flags_r <= '0;
      state_r <= ST_HUNT;
      crc_r <= CRC_PRESET;
      bitcnt_r <= 3'h0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      ie_r <= ie_nxt;
      ignore_message_control_r <= ignore_message_control_nxt;
      tx_pending_r <= tx_pending_nxt;
      need_eof_r <= need_eof_nxt;
      tx_enable_r <= tx_enable_nxt;
      tx_abort_r <= tx_abort_nxt;
      flags_r <= flags_nxt;
      state_r <= state_nxt;
      crc_r <= crc_nxt;
      bitcnt_r <= bitcnt_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // zero-wait slave; break generation is deliberately absent
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign tx_enable = tx_enable_r;
  assign tx_abort = tx_abort_r;
  assign irq = ie_r && !ignore_message_control_r && (svr != SVR_NONE);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_tx_err_irq: assert property (flags_r.txerr && ie_r && !ignore_message_control_r |-> irq)
    else $error("pending transmission error without interrupt");
  a_no_irq_off: assert property (!ie_r |-> !irq)
    else $error("interrupt raised while disabled");
  a_crc_flag_set: assert property (crc_bad |=> flags_r.crc && state_r == ST_WAIT_EOF)
    else $error("crc error not flagged or frame not dropped");
  a_brk_wait_sof: assert property (sym_live && sym.kind == SYM_BRK
    |=> flags_r.inv && state_r == ST_WAIT_IDLE)
    else $error("break did not flag or wait for idle");
  a_short_no_start: assert property (bus_s_r |=> !tx_enable_r)
    else $error("transmission enabled on an active bus");
  a_eof_owed: assert property (need_eof_r && sym.kind != SYM_EOF |=> !tx_enable_r)
    else $error("transmission enabled before end of frame");
  a_gnd_abort: assert property (tx.sending && !ignore_message_control_r && drv_echo && !bus_s_r
    |=> tx_abort_r && flags_r.txerr && flags_r.inv && !tx_pending_r)
    else $error("ground short not aborted");
  a_abort_no_retry: assert property (tx_abort_r |-> !tx_pending_r ##1 !tx_enable_r)
    else $error("transmission retried after abort");
  a_ignore_message_control_hold: assert property (ignore_message_control_r && $past(ignore_message_control_r) |-> flags_r == '0)
    else $error("status changed while ignoring");
  a_svr_priority: assert property (flags_r.inv |-> hrdata_nxt[7:0] == SVR_INVALID
    || !(addr_phase && !hwrite && haddr == ADDR_SVR))
    else $error("state vector not highest priority");

  c_break_seen: cover property (sym_live && sym.kind == SYM_BRK ##1 state_r == ST_WAIT_IDLE);
  c_crc_error: cover property (crc_bad ##1 flags_r.crc);
  c_gnd_short: cover property (tx.sending && drv_echo && !bus_s_r ##1 tx_abort_r);
  c_frame_ok: cover property (sym_live && sym.kind == SYM_EOF && state_r == ST_FRAME);
endmodule : vpw_bus_error_handler
`default_nettype wire

// >>> design/vpw_err_pkg.sv
/*
  Constants, register map and carrier types of the J1850 VPW bus error handler.
  Assumes a neighbouring symbol decoder and transmitter on the same clock.
*/
// Summary of operation
// - Own message with invalid bits or misplaced framing is a transmission error; stop driving.
// - Transmission error shows in state vector; irq only with irq_enable_bit set.
// - Run CRC over received data and CRC byte; mismatch sets CRC error flag.
// - CRC catches all single, double and up to 8-bit burst errors.
// - CRC error raises its interrupt, then bus ignored until end of frame.
// - Invalid symbol in a received message sets the invalid symbol status.
// - EOD or EOF off a byte boundary is a framing error.
// - Active symbol seen while sending EOD is a framing error.
// - Framing error sets invalid symbol status, interrupts, then waits for end of frame.
// - Noise bits while transmitting abort at once and raise invalid symbol.
// - Bus held active by battery short: never start a transmission.
// - After supply short need end-of-frame before retrying; may set loss of arbitration.
// - Ground short: start sending, then see transmission error as SOF cannot drive.
// - After ground short abort, no retry until a new CPU transmit command.
// - Ground short reported as invalid symbol; end of frame needed before retrying.
// - Once a temporary fault clears, normal operation resumes with no special action.
// - Break while sending or receiving raises invalid symbol; state vector read clears it.
// - After break wait for idle bus, then for the next valid start of frame.
// - Never generate a break symbol; only detect them.
// - Interrupt request holds until all sources cleared or reset zeroes the vector.
// - Ignore-message control disables receiver, holds status until SOF or break clears it; code zeroes the flags while ignoring instead.
package vpw_err_pkg;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_SVR = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam int CTRL_IE_BIT = 0;
  localparam int CTRL_IGNORE_MESSAGE_CONTROL_BIT = 1;
  localparam int CTRL_TXGO_BIT = 2;
  localparam logic CTRL_IE_RESET = 1'b0;
  localparam logic CTRL_IGNORE_MESSAGE_CONTROL_RESET = 1'b0;
  localparam logic [7:0] SVR_NONE = 8'h00;
  localparam logic [7:0] SVR_INVALID = 8'h1c;
  localparam logic [7:0] SVR_CRC = 8'h18;
  localparam logic [7:0] SVR_TXERR = 8'h14;
  localparam logic [7:0] SVR_EOF = 8'h08;
  localparam logic [7:0] SVR_LOA = 8'h04;
  localparam logic [7:0] CRC_PRESET = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_RESIDUE = 8'hc4;
  localparam int DRIVE_DELAY = 2;

  typedef enum logic [2:0] {
    SYM_DATA0 = 3'b000,
    SYM_DATA1 = 3'b001,
    SYM_SOF = 3'b010,
    SYM_EOD = 3'b011,
    SYM_EOF = 3'b100,
    SYM_BRK = 3'b101,
    SYM_INVALID = 3'b110
  } sym_kind_t;

  typedef struct packed {
    logic valid;
    sym_kind_t kind;
  } sym_t;

  typedef struct packed {
    logic sending;
    logic eod_phase;
    logic drive_active;
  } tx_stat_t;

  typedef struct packed {
    logic inv;
    logic crc;
    logic txerr;
    logic eof;
    logic loss_of_arbitration_flag;
  } flags_t;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_FRAME = 2'b01,
    ST_WAIT_EOF = 2'b10,
    ST_WAIT_IDLE = 2'b11
  } rx_state_t;
endpackage : vpw_err_pkg

// >>> verification/tb_vpw_bus_error_handler.sv
/*
  Self-checking bench of the bus error handler: AHB-Lite register tasks and symbol traffic.
  Assumes the design's package and the vpw_bus_node far-side model.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) \
  begin \
    compares++; \
    if ((a) !== (e)) \
    begin \
      fails++; \
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); \
    end \
  end
module tb_vpw_bus_error_handler;
  import vpw_err_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  sym_t sym;
  tx_stat_t tx;
  logic bus_rx;
  logic tx_enable;
  logic tx_abort;
  logic irq;
  logic [31:0] rd;
  int fails = 0;
  int compares = 0;
  logic [7:0] masks [4] = '{8'h01, 8'h24, 8'hff, 8'h3c};
  sym_kind_t ends [4] = '{SYM_EOD, SYM_EOF, SYM_INVALID, SYM_BRK};
  int nbits [4] = '{3, 5, 8, 4};
  assign hready = hreadyout;
  vpw_bus_error_handler dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sym(sym), .tx(tx),
    .bus_rx(bus_rx), .tx_enable(tx_enable), .tx_abort(tx_abort), .irq(irq));
  vpw_bus_node node (.clk(clk), .resetn(resetn), .tx_enable(tx_enable),
    .tx_abort(tx_abort), .sym(sym), .tx(tx), .bus_rx(bus_rx));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task tdone(input string name);
    $display("test %s done", name);
  endtask : tdone
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task chk_svr(input logic [7:0] e);
    ahb(1'b0, ADDR_SVR, 32'h0);
    `CHK("state vector", e, rd[7:0]);
    `CHK("hresp", 1'b0, hresp);
  endtask : chk_svr
  task drain();
    repeat (4) ahb(1'b0, ADDR_SVR, 32'h0);
  endtask : drain
  // expected check byte: msb first, preset ones, complemented remainder
  function automatic logic [7:0] crc_of(input logic [7:0] d);
    logic [7:0] c;
    c = CRC_PRESET;
    for (int i = 7; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return ~c;
  endfunction : crc_of
  task frame(input logic [7:0] d, input logic [7:0] mask, input logic noise);
    node.send_sym(SYM_SOF);
    node.send_byte(d ^ mask);
    node.send_byte(crc_of(d));
    node.send_sym(SYM_EOD);
    if (noise)
      node.send_sym(SYM_INVALID);
    node.send_sym(SYM_EOF);
    idle(3);
  endtask : frame
  task bad(input int n, input sym_kind_t k);
    node.send_sym(SYM_SOF);
    repeat (n) node.send_sym(SYM_DATA1);
    node.send_sym(k);
    node.send_sym(SYM_EOF);
    idle(3);
  endtask : bad
  // whole run is under a thousand cycles; this span is 30000 cycles, over thirty times that
  initial
  begin
    #300000;
    fails++;
    summarize();
  end
  initial
  begin
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    `CHK("irq", 1'b0, irq);
    `CHK("tx_enable", 1'b0, tx_enable);
    ahb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, rd);
    chk_svr(SVR_NONE);
    ahb(1'b0, 32'h0000_0010, 32'h0);
    `CHK("unmapped", 32'h0, rd);
    tdone("reset");
    ahb(1'b1, ADDR_CTRL, 32'h1);
    frame(8'h5a, 8'h00, 1'b0);
    chk_svr(SVR_EOF);
    chk_svr(SVR_NONE);
    `CHK("irq", 1'b0, irq);
    tdone("good frame");
    foreach (masks[i])
    begin
      frame(8'hc3, masks[i], 1'b1);
      `CHK("irq", 1'b1, irq);
      chk_svr(SVR_CRC);
      `CHK("irq held", 1'b1, irq);
      chk_svr(SVR_EOF);
      chk_svr(SVR_NONE);
    end
    tdone("crc errors");
    // odd entries run with the interrupt enabled, even ones without
    foreach (ends[i])
    begin
      ahb(1'b1, ADDR_CTRL, {31'h0, i[0]});
      bad(nbits[i], ends[i]);
      `CHK("irq", i[0], irq);
      chk_svr(SVR_INVALID);
      drain();
    end
    node.send_sym(SYM_SOF);
    node.send_sym(SYM_BRK);
    node.send_byte(8'h00);
    node.send_sym(SYM_EOD);
    idle(3);
    chk_svr(SVR_INVALID);
    chk_svr(SVR_NONE);
    node.send_sym(SYM_EOF);
    drain();
    tdone("framing and break");
    ahb(1'b1, ADDR_CTRL, 32'h3);
    node.send_sym(SYM_INVALID);
    node.send_sym(SYM_EOF);
    idle(3);
    `CHK("irq", 1'b0, irq);
    chk_svr(SVR_NONE);
    frame(8'h11, 8'h80, 1'b0);
    ahb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd);
    chk_svr(SVR_CRC);
    drain();
    tdone("ignore message");
    node.gnd_short <= 1'b1;
    ahb(1'b1, ADDR_CTRL, 32'h5);
    idle(30);
    `CHK("starts", 1, node.starts);
    `CHK("aborts", 1, node.aborts);
    chk_svr(SVR_INVALID);
    chk_svr(SVR_TXERR);
    node.gnd_short <= 1'b0;
    idle(20);
    `CHK("starts", 1, node.starts);
    ahb(1'b1, ADDR_CTRL, 32'h5);
    idle(20);
    `CHK("starts", 1, node.starts);
    node.send_sym(SYM_EOF);
    idle(10);
    `CHK("starts", 2, node.starts);
    idle(30);
    drain();
    tdone("ground short");
    node.bat_short <= 1'b1;
    ahb(1'b1, ADDR_CTRL, 32'h5);
    idle(20);
    `CHK("starts", 2, node.starts);
    `CHK("tx_enable", 1'b0, tx_enable);
    node.bat_short <= 1'b0;
    node.send_sym(SYM_EOF);
    idle(10);
    `CHK("starts", 3, node.starts);
    idle(30);
    drain();
    tdone("battery short");
    // noise in our own frame, then an active symbol while sending EOD
    ahb(1'b1, ADDR_CTRL, 32'h5);
    idle(3);
    node.send_sym(SYM_INVALID);
    idle(5);
    `CHK("aborts", 2, node.aborts);
    chk_svr(SVR_INVALID);
    chk_svr(SVR_TXERR);
    node.send_sym(SYM_EOF);
    node.eod_mode <= 1'b1;
    ahb(1'b1, ADDR_CTRL, 32'h5);
    idle(3);
    node.send_sym(SYM_DATA0);
    idle(5);
    `CHK("starts", 5, node.starts);
    `CHK("aborts", 3, node.aborts);
    chk_svr(SVR_INVALID);
    chk_svr(SVR_EOF);
    tdone("transmit errors");
    summarize();
  end
endmodule : tb_vpw_bus_error_handler
`default_nettype wire

// >>> verification/vpw_bus_node.sv
/*
  Far-side model: other J1850 nodes as decoded symbols, plus the local transmitter.
  Assumes the handler's clk and resetn; bus faults are switched on by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module vpw_bus_node
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tx_enable,
  input wire logic tx_abort,
  output var vpw_err_pkg::sym_t sym,
  output var vpw_err_pkg::tx_stat_t tx,
  output logic bus_rx
);
  import vpw_err_pkg::*;
  logic gnd_short = 1'b0;
  logic bat_short = 1'b0;
  logic eod_mode = 1'b0;
  int starts;
  int aborts;
  int tcnt;
  // pulled-down bus: passive reads 0 once nobody drives it
  assign bus_rx = bat_short | (tx.drive_active & ~gnd_short);
  initial sym = '0;
  task send_sym(input sym_kind_t k);
    @(posedge clk);
    sym <= {1'b1, k};
    @(posedge clk);
    sym <= '0;
  endtask : send_sym
  task send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      send_sym(b[i] ? SYM_DATA1 : SYM_DATA0);
  endtask : send_byte
  // frame length is fixed; only the start and the abort matter here
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx <= '0;
      tcnt <= 0;
      starts <= 0;
      aborts <= 0;
    end
    else if (tx_abort)
    begin
      tx <= '0;
      // the abort may stand a second cycle; count only the one that stops us
      if (tx.sending)
        aborts <= aborts + 1;
    end
    else if (tx.sending)
    begin
      tcnt <= tcnt + 1;
      if (tcnt == 20)
        tx <= '0;
    end
    else if (tx_enable)
    begin
      tx <= {1'b1, eod_mode, 1'b1};
      tcnt <= 0;
      starts <= starts + 1;
    end
  end
endmodule : vpw_bus_node
`default_nettype wire
